/* File: inc/diag_pkg.sv */
// Constants and types for the diagnostic register bank and front-panel status display.
// Assumes a single 200 MHz clock domain; all numbers of the block live here.
package diag_pkg;

	// ------------------------------------------------------------
	// Diagnostic identifiers and address handling
	// ------------------------------------------------------------
	localparam logic [7:0] ID_ERROR_FLAGS  = 8'h10; // Identifier 16.
	localparam logic [7:0] ID_ERROR_DETAIL = 8'h11; // Identifier 17.
	localparam logic [7:0] WORD_STEP       = 8'h02; // Registers sit one word below a base.
	localparam logic [7:0] ADDR_MAX        = 8'hfe; // Highest valid word address, 254.

	// ------------------------------------------------------------
	// Error flag bit positions
	// ------------------------------------------------------------
	localparam int BIT_PERIPH = 0;
	localparam int BIT_LOCAL  = 1;
	localparam int BIT_REMOTE = 2;
	localparam int BIT_CTRL   = 3;
	localparam int NUM_FAULTS = 4;

	// ------------------------------------------------------------
	// Area selector codes and display symbols
	// ------------------------------------------------------------
	localparam logic [3:0] AREA_P_IN  = 4'h0;
	localparam logic [3:0] AREA_P_OUT = 4'h1;
	localparam logic [3:0] AREA_Q_IN  = 4'h2;
	localparam logic [3:0] AREA_Q_OUT = 4'h3;
	localparam logic [15:0] SYM_DASH    = 16'h2d2d; // Two dashes.
	localparam logic [15:0] SYM_BADADDR = 16'h4164; // Two characters "Ad".
	localparam logic [15:0] RESET_WORD  = 16'h0000;

	typedef enum logic {START_AUTO, START_CONTROLLED} start_mode_e;

endpackage

/* File: design/fault_latch.sv */
// Edge latch for one fault: sticky on a rising edge, cleared by a host command.
// Assumes its fault input is already synchronous to clk.
`timescale 1ns/1ps
module fault_latch (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Fault in, clear in, held flag out
	input  wire logic faultIn,
	input  wire logic clearReq,
	output logic      held
);
	logic prev_q, prev_d, held_q, held_d;

	// A new rising edge beats a clear in the same cycle so no event is lost.
	always_comb begin
		prev_d = faultIn;
		held_d = held_q;
		if (clearReq)
			held_d = 1'b0;
		if (faultIn && !prev_q)
			held_d = 1'b1;
	end

	// Registers only.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 1'b0;
			held_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			held_q <= held_d;
		end
	end

	assign held = held_q;
endmodule

/* File: design/diag_register_status_display.sv */
// Diagnostic register bank and front-panel I/O status display.
// Assumes fault and switch inputs are asynchronous pins; the input-area read port and
// the window bases come from same-clock logic.
//
// Overview of operation
// - Two one-word diagnostic registers mirror panel lamps and numeric display.
// - Each flag bit marks one fault class; 1 means currently active, except the peripheral bit, which holds until cleared.
// - Detail register equals the value currently on the numeric display.
// - Automatic start: flag register sits at first window base minus two.
// - Automatic start: detail register sits at second window base minus two.
// - Controlled start: identifier 16 and 17 registers sit at assigned addresses.
// - Area selector 0..3 picks P inputs, P outputs, Q inputs, Q outputs.
// - Module address from switches valid only if even and 0 to 254.
// - Invalid address blanks the lamps and, with no fault active, shows the Ad symbol.
// - Valid selection shows the addressed data as a 16-bit lamp word.
// - Valid selection with no fault active shows a dash symbol on the numeric display.
// - Peripheral fault latches on rising edge until host clears it.
`timescale 1ns/1ps
module diag_register_status_display (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Fault pins
	input  wire logic                  peripheral_module_fault,
	input  wire logic                  local_segment_fault,
	input  wire logic                  remote_segment_fault,
	input  wire logic                  controllerFault,
	input  wire logic                  clearFault,
	input  wire logic [15:0]           faultCode,
	// Start mode and address assignment
	input  wire diag_pkg::start_mode_e startMode,
	input  wire logic [7:0]            window1Base,
	input  wire logic [7:0]            window2Base,
	input  wire logic [7:0]            assignId,
	input  wire logic [7:0]            assignAddr,
	input  wire logic                  assignStrobe,
	// Controller input-area read port
	input  wire logic [7:0]            input_word_operand,
	output logic                       readHit,
	output logic [15:0]                readData,
	// Operator switches and module data view
	input  wire logic [3:0]            areaSwitch,
	input  wire logic [7:0]            addrSwitch,
	output logic [1:0]                 viewArea,
	output logic [7:0]                 viewAddr,
	input  wire logic [15:0]           viewData,
	input  wire logic                  viewOccupied,
	// Panel outputs
	output logic [15:0]                statusLamps,
	output logic [15:0]                numericDisplay,
	output logic [3:0]                 faultLamps
);
	import diag_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int SYNC_W = NUM_FAULTS + 1 + 4 + 8;
	logic [SYNC_W-1:0] sync1_q, sync2_q, sync1_d, sync2_d;
	logic              periphS, localS, remoteS, ctrlS, clearS;
	logic [3:0]        areaS;
	logic [7:0]        addrS;

	// Stage one is read by stage two only.
	always_comb begin
		sync1_d = {peripheral_module_fault, local_segment_fault, remote_segment_fault,
			controllerFault, clearFault, areaSwitch, addrSwitch};
		sync2_d = sync1_q;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	assign {periphS, localS, remoteS, ctrlS, clearS, areaS, addrS} = sync2_q;

	// ------------------------------------------------------------
	// Fault flags
	// ------------------------------------------------------------
	logic periphHeld;
	logic clearPrev_q, clearPrev_d, clearPulse;

	// The clear pin acts once per press, not for as long as it is held.
	always_comb clearPrev_d = clearS;
	assign clearPulse = clearS && !clearPrev_q;

	fault_latch periphLatch (
		.clk     (clk),
		.reset_n (reset_n),
		.faultIn (periphS),
		.clearReq(clearPulse),
		.held    (periphHeld)
	);

	// Bus faults are live levels; only the peripheral fault is sticky.
	logic [15:0] flagsWord;
	always_comb begin
		flagsWord = RESET_WORD;
		flagsWord[BIT_PERIPH] = periphHeld;
		flagsWord[BIT_LOCAL]  = localS;
		flagsWord[BIT_REMOTE] = remoteS;
		flagsWord[BIT_CTRL]   = ctrlS;
	end

	// ------------------------------------------------------------
	// Front-panel selection
	// ------------------------------------------------------------
	logic addrValid, areaLegal, anyFault;
	logic [15:0] lamps_q, lamps_d, disp_q, disp_d;

	// Odd or unoccupied addresses are refused; 254 is the top even code anyway.
	assign addrValid = !addrS[0] && (addrS <= ADDR_MAX) && viewOccupied;
	// Forbidden area codes are not decoded; the lamps go blank and, with no fault active, the display shows the Ad symbol.
	assign areaLegal = (areaS <= AREA_Q_OUT);
	assign viewArea  = areaS[1:0];
	assign viewAddr  = addrS;

	// Any active flag bit hands the numeric display over to the fault code.
	assign anyFault = |flagsWord[NUM_FAULTS-1:0];

	// Active faults take the numeric display; otherwise it shows selection state.
	// The lamps keep showing a valid selection during a fault, so the operator
	// can still watch module data while the display carries the fault detail.
	always_comb begin
		lamps_d = RESET_WORD;
		if (addrValid && areaLegal)
			lamps_d = viewData;
		if (anyFault) begin
			disp_d = faultCode;
		end else if (!addrValid || !areaLegal) begin
			disp_d = SYM_BADADDR;
		end else begin
			disp_d = SYM_DASH;
		end
	end

	// ------------------------------------------------------------
	// Register placement
	// ------------------------------------------------------------
	logic [7:0] flagsAddr_q, flagsAddr_d, detailAddr_q, detailAddr_d;
	logic       flagsMapped_q, flagsMapped_d, detailMapped_q, detailMapped_d;

	// Controlled start keeps the last address paired with each identifier.
	always_comb begin
		flagsAddr_d    = flagsAddr_q;
		detailAddr_d   = detailAddr_q;
		flagsMapped_d  = flagsMapped_q;
		detailMapped_d = detailMapped_q;
		if (assignStrobe && assignId == ID_ERROR_FLAGS) begin
			flagsAddr_d   = assignAddr;
			flagsMapped_d = 1'b1;
		end
		if (assignStrobe && assignId == ID_ERROR_DETAIL) begin
			detailAddr_d   = assignAddr;
			detailMapped_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clearPrev_q    <= 1'b0;
			lamps_q        <= RESET_WORD;
			disp_q         <= RESET_WORD;
			flagsAddr_q    <= '0;
			detailAddr_q   <= '0;
			flagsMapped_q  <= 1'b0;
			detailMapped_q <= 1'b0;
		end else begin
			clearPrev_q    <= clearPrev_d;
			lamps_q        <= lamps_d;
			disp_q         <= disp_d;
			flagsAddr_q    <= flagsAddr_d;
			detailAddr_q   <= detailAddr_d;
			flagsMapped_q  <= flagsMapped_d;
			detailMapped_q <= detailMapped_d;
		end
	end

	// ------------------------------------------------------------
	// Read-only input-area port
	// ------------------------------------------------------------
	logic       hitFlags, hitDetail;
	logic [7:0] autoFlags, autoDetail;

	assign autoFlags  = window1Base - WORD_STEP;
	assign autoDetail = window2Base - WORD_STEP;

	always_comb begin
		if (startMode == START_AUTO) begin
			hitFlags  = (input_word_operand == autoFlags);
			hitDetail = (input_word_operand == autoDetail);
		end else begin
			hitFlags  = flagsMapped_q && (input_word_operand == flagsAddr_q);
			hitDetail = detailMapped_q && (input_word_operand == detailAddr_q);
		end
	end

	// No write path exists; contents track the panel every cycle.
	assign readHit  = hitFlags || hitDetail;
	assign readData = hitFlags ? flagsWord : (hitDetail ? disp_q : RESET_WORD);

	assign statusLamps    = lamps_q;
	assign numericDisplay = disp_q;
	assign faultLamps     = flagsWord[NUM_FAULTS-1:0];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_odd_addr_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(addrS[0] && !anyFault) |=> (disp_q == SYM_BADADDR))
		else $error("Odd address did not show the invalid symbol.");
	a_valid_dash: assert property (@(posedge clk) disable iff (!reset_n)
		(addrValid && areaLegal && !anyFault) |=> (disp_q == SYM_DASH))
		else $error("Valid address did not show the dash.");
	a_lamps_data: assert property (@(posedge clk) disable iff (!reset_n)
		(addrValid && areaLegal) |=> (lamps_q == $past(viewData)))
		else $error("Status lamps do not carry the selected word.");
	a_auto_flags_map: assert property (@(posedge clk) disable iff (!reset_n)
		(startMode == START_AUTO && input_word_operand == window1Base - WORD_STEP)
		|-> (readHit && readData == flagsWord))
		else $error("Flag register not at first base minus two.");
	a_auto_detail_map: assert property (@(posedge clk) disable iff (!reset_n)
		(startMode == START_AUTO && input_word_operand == window2Base - WORD_STEP
		&& input_word_operand != window1Base - WORD_STEP) |-> (readData == disp_q))
		else $error("Detail register not at second base minus two.");
	a_ctrl_id_map: assert property (@(posedge clk) disable iff (!reset_n)
		(assignStrobe && assignId == ID_ERROR_FLAGS && startMode == START_CONTROLLED)
		##1 (input_word_operand == $past(assignAddr) && startMode == START_CONTROLLED)
		|-> readHit)
		else $error("Assigned flag address does not answer.");
	a_periph_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		(periphHeld && !clearPulse) |=> periphHeld)
		else $error("Peripheral fault dropped without a clear.");
	a_fault_flag_live: assert property (@(posedge clk) disable iff (!reset_n)
		(hitFlags && $past(reset_n, 2))
		|-> (readData[BIT_LOCAL] == $past(local_segment_fault, 2)))
		else $error("Local fault bit does not follow its pin.");
	a_detail_mirror: assert property (@(posedge clk) disable iff (!reset_n)
		anyFault |=> (disp_q == $past(faultCode)))
		else $error("Numeric display does not carry the fault code.");
endmodule

/* File: bench/module_store.sv */
// Partner model: module data store answering the panel's address selection.
// Assumes the selector outputs come from registers in the same clock domain.
`timescale 1ns/1ps
module module_store (
	// Selection in
	input  wire logic [1:0]  viewArea,
	input  wire logic [7:0]  viewAddr,
	// Answer out
	output logic      [15:0] viewData,
	output logic             viewOccupied
);
	// Data encodes area and address so a wrong pick shows; address 0x20 is left empty in every area.
	assign viewData     = {6'h2a, viewArea, viewAddr};
	assign viewOccupied = (viewAddr != 8'h20);
endmodule

/* File: bench/diag_register_status_display_test.sv */
// Self-checking bench for the diagnostic register bank and status display.
// Assumes the hand-over latencies: pins settle within five edges, reads are combinational.
`timescale 1ns/1ps
module diag_register_status_display_test;
	import diag_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observation signals
	// ------------------------------------------------------------
	logic        clk = 1'b0, reset_n = 1'b0, clearFault, assignStrobe, readHit;
	logic [3:0]  fl, areaSwitch, faultLamps;
	logic [15:0] faultCode, readData, viewData, statusLamps, numericDisplay;
	logic [7:0]  window1Base, window2Base, assignId, assignAddr, input_word_operand;
	logic [7:0]  addrSwitch, viewAddr;
	logic [1:0]  viewArea;
	logic        viewOccupied;
	start_mode_e startMode;
	int          fails = 0, compares = 0;
	logic [7:0]  adr [4] = '{8'h41, 8'h20, 8'hfe, 8'h00};

	// Half-period inversion gives the 200 MHz clock.
	always #2.5 clk = ~clk;

	diag_register_status_display uut (.clk(clk), .reset_n(reset_n),
		.peripheral_module_fault(fl[0]), .local_segment_fault(fl[1]),
		.remote_segment_fault(fl[2]), .controllerFault(fl[3]), .clearFault(clearFault),
		.faultCode(faultCode), .startMode(startMode), .window1Base(window1Base),
		.window2Base(window2Base), .assignId(assignId), .assignAddr(assignAddr),
		.assignStrobe(assignStrobe), .input_word_operand(input_word_operand),
		.readHit(readHit), .readData(readData), .areaSwitch(areaSwitch),
		.addrSwitch(addrSwitch), .viewArea(viewArea), .viewAddr(viewAddr),
		.viewData(viewData), .viewOccupied(viewOccupied), .statusLamps(statusLamps),
		.numericDisplay(numericDisplay), .faultLamps(faultLamps));

	module_store store (.viewArea(viewArea), .viewAddr(viewAddr), .viewData(viewData),
		.viewOccupied(viewOccupied));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Inputs always change the same small delay after the rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic h, input logic [15:0] d);
		input_word_operand = a;
		#1;
		check({15'h0, readHit}, {15'h0, h});
		check(readData, d);
		tick(1);
	endtask

	task automatic asg(input logic [7:0] id, input logic [7:0] a);
		assignId = id;
		assignAddr = a;
		assignStrobe = 1'b1;
		tick(1);
		assignStrobe = 1'b0;
		input_word_operand = a;
		tick(1);
	endtask

	task automatic final_report;
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog: the tests need about 130 cycles, so this span means a hang.
	initial begin
		#20000;
		fails++;
		final_report;
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		fl = 4'h0; clearFault = 1'b0; assignStrobe = 1'b0; assignId = 8'h00;
		assignAddr = 8'h00; input_word_operand = 8'h00; faultCode = 16'hbeef;
		startMode = START_AUTO; window1Base = 8'h40; window2Base = 8'h80;
		areaSwitch = 4'h0; addrSwitch = 8'h10;
		tick(6);
		reset_n = 1'b1;
		tick(5);
		rd(8'h3e, 1'b1, 16'h0000);
		rd(8'h7e, 1'b1, SYM_DASH);
		rd(8'h40, 1'b0, 16'h0000);
		$display("test auto_map done");
		for (int i = 0; i < 4; i++) begin
			areaSwitch = i[3:0];
			tick(5);
			check({14'h0, viewArea}, i[15:0]);
			check(statusLamps, {6'h2a, i[1:0], 8'h10});
		end
		$display("test areas done");
		// Odd, empty, top boundary and zero addresses.
		for (int i = 0; i < 4; i++) begin
			addrSwitch = adr[i];
			tick(5);
			check(numericDisplay, (i < 2) ? SYM_BADADDR : SYM_DASH);
			check(statusLamps, (i < 2) ? 16'h0000 : {8'hab, adr[i]});
			check({8'h0, viewAddr}, {8'h0, adr[i]});
		end
		$display("test addresses done");
		for (int i = 0; i < 4; i++) begin
			fl = 4'h1 << i;
			tick(5);
			rd(8'h3e, 1'b1, 16'(1 << i));
			check({12'h0, faultLamps}, {12'h0, fl});
			check(statusLamps, 16'hab00);
			rd(8'h7e, 1'b1, 16'hbeef);
			fl = 4'h0;
			tick(5);
			rd(8'h3e, 1'b1, (i == 0) ? 16'h0001 : 16'h0000);
			if (i == 0) begin
				clearFault = 1'b1;
				tick(5);
				clearFault = 1'b0;
				tick(5);
				rd(8'h3e, 1'b1, 16'h0000);
			end
		end
		$display("test faults done");
		startMode = START_CONTROLLED;
		tick(2);
		rd(8'h3e, 1'b0, 16'h0000);
		// Host lists the diagnostic identifiers after its other entries.
		asg(8'h05, 8'h30);
		asg(ID_ERROR_FLAGS, 8'h20);
		asg(ID_ERROR_DETAIL, 8'h22);
		rd(8'h30, 1'b0, 16'h0000);
		rd(8'h20, 1'b1, 16'h0000);
		rd(8'h22, 1'b1, SYM_DASH);
		$display("test controlled done");
		final_report;
	end
endmodule
